// file: rtl/phy_dual.sv
// PHY end: transmit FIFO, one port's link logic, and the dual-port top
// How it works
// R1: MII transmit clock 25 or 2.5 MHz
// R2: RMII uses only the 50 MHz reference
// R3: Serial mode transmit clock is 10 MHz
// R4: MII transmit enable marks valid nibbles
// R5: RMII dibits taken only under transmit enable
// R6: Serial bit taken only under transmit enable
// R7: MII nibbles sampled on transmit clock
// R8: RMII dibits sampled on reference clock
// R9: Serial path one bit, other inputs ignored
// R10: MII receive clock 25 or 2.5 MHz
// R11: Serial receive clock is 10 MHz
// R12: MII receive valid exactly over valid data
// R13: RMII still drives receive data valid
// R14: Serial mode leaves receive valid low
// R15: MII 100 Mb/s flags invalid symbols
// R16: MII receive nibbles timed to receive clock
// R17: RMII receive dibits on reference clock
// R18: RMII error on bad symbol, false carrier
// R19: Collision only in half duplex
// R20: Two independent port copies
// R21: Mode fixed after configuration capture
`timescale 1ns/1ps
module phy_fifo #(
	parameter int W = 5,
	parameter int D = 16
) (
	// Clock and reset
	input  wire logic         i_core_clk,
	input  wire logic         i_rst_b,
	// Fill side
	input  wire logic         i_in_valid,
	output logic              o_in_ready,
	input  wire logic [W-1:0] i_in_data,
	// Drain side
	output logic              o_out_valid,
	input  wire logic         i_out_ready,
	output logic      [W-1:0] o_out_data
);
	localparam int AW = $clog2(D);
	localparam int CW = $clog2(D + 1);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [CW-1:0]       cnt;
	} fifo_st_t;
	fifo_st_t r;
	fifo_st_t n;
	logic     wr;
	logic     rd;

	assign o_in_ready  = (r.cnt != CW'(D));
	assign o_out_valid = (r.cnt != '0);
	assign o_out_data  = r.mem[r.rp];

	always_comb begin
		n  = r;
		wr = i_in_valid && o_in_ready;
		rd = o_out_valid && i_out_ready;
		if (wr) begin
			n.mem[r.wp] = i_in_data;
			n.wp        = (r.wp == AW'(D - 1)) ? '0 : r.wp + 1'b1;
		end
		if (rd) begin
			n.rp = (r.rp == AW'(D - 1)) ? '0 : r.rp + 1'b1;
		end
		if (wr && !rd) begin
			n.cnt = r.cnt + 1'b1;
		end else if (rd && !wr) begin
			n.cnt = r.cnt - 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
endmodule : phy_fifo

module phy_port (
	// Clock and reset
	input  wire logic                i_core_clk,
	input  wire logic                i_rst_b,
	// Configuration, captured once after reset
	input  wire phy_mac_pkg::mode_t  i_mode,
	input  wire logic                i_speed_100,
	input  wire logic                i_full_duplex,
	// MAC link
	phy_mac_if.phy                   link,
	// Received line data towards the MAC
	input  wire logic                i_rx_crs,
	input  wire logic                i_rx_valid,
	output logic                     o_rx_ready,
	input  wire logic [3:0]          i_rx_data,
	input  wire logic                i_rx_sym_err,
	input  wire logic                i_false_carrier,
	// Transmitted nibbles towards the line
	output logic                     o_tx_valid,
	input  wire logic                i_tx_ready,
	output logic [3:0]               o_tx_data,
	output logic                     o_tx_first
);
	import phy_mac_pkg::*;

	typedef struct packed {
		logic       cfg_ok;
		mode_t      mode;
		logic       spd100;
		logic       fdx;
		logic [5:0] tcnt;
		logic [5:0] rcnt;
		logic       tclk;
		logic       rclk;
		logic [3:0] tsh;
		logic [1:0] tn;
		logic       in_frame;
		logic [3:0] rsh;
		logic [1:0] rn;
		logic [3:0] rxd;
		logic       rx_dv;
		logic       rx_er;
		logic       crs;
		logic       col;
	} port_st_t;
	port_st_t   r;
	port_st_t   n;
	logic       fifo_in_ready;
	logic       push;
	logic [4:0] pword;
	logic [4:0] fifo_out;
	logic [5:0] div;
	logic       ttick;
	logic       rtick;
	logic       rmii;
	logic       ser;

	assign rmii = (r.mode == MODE_RMII);
	assign ser  = (r.mode == MODE_SERIAL);

	// R1 R3 R10 R11 clock rates
	assign div = rmii ? DIV_RMII : ser ? DIV_SERIAL :
		r.spd100 ? DIV_MII100 : DIV_MII10;

	// R2 reference only in RMII
	assign link.tx_clk  = rmii ? 1'b0 : r.tclk;
	assign link.rx_clk  = rmii ? 1'b0 : r.rclk;
	assign link.ref_clk = rmii ? r.tclk : 1'b0;
	assign link.rxd     = r.rxd;
	assign link.rx_dv   = r.rx_dv;
	assign link.rx_er   = r.rx_er;
	assign link.crs     = r.crs;
	assign link.col     = r.col;
	assign o_tx_data    = fifo_out[3:0];
	assign o_tx_first   = fifo_out[4];
	assign o_rx_ready   = rtick && r.cfg_ok && (r.rn == UNIT_FIRST);

	always_comb begin
		n     = r;
		push  = 1'b0;
		pword = '0;
		ttick = 1'b0;
		rtick = 1'b0;
		// R21 one-time mode capture
		if (!r.cfg_ok) begin
			n.cfg_ok = 1'b1;
			n.mode   = i_mode;
			n.spd100 = i_speed_100;
			n.fdx    = i_full_duplex;
		end
		// A full FIFO holds the clock low, which stalls the MAC
		if (r.tcnt >= div - 6'h01) begin
			if (fifo_in_ready) begin
				n.tcnt = '0;
				ttick  = 1'b1;
			end
		end else begin
			n.tcnt = r.tcnt + 6'h01;
		end
		n.tclk = (n.tcnt < (div >> 1));
		// R17 RMII receive shares the reference
		if (rmii) begin
			rtick  = ttick;
			n.rcnt = '0;
		end else if (r.rcnt >= div - 6'h01) begin
			n.rcnt = '0;
			rtick  = 1'b1;
		end else begin
			n.rcnt = r.rcnt + 6'h01;
		end
		n.rclk = (n.rcnt < (div >> 1));
		// R7 R8 sample at clock rise
		if (ttick && r.cfg_ok) begin
			// R4 R5 R6 enable qualifies data
			if (link.tx_en) begin
				case (r.mode)
					MODE_MII: begin
						push  = 1'b1;
						pword = {!r.in_frame, link.txd};
					end
					MODE_RMII: begin
						if (r.tn == UNIT_FIRST) begin
							n.tsh[1:0] = link.txd[1:0];
							n.tn       = UNITS_RMII_LAST;
						end else begin
							push  = 1'b1;
							pword = {!r.in_frame, link.txd[1:0], r.tsh[1:0]};
							n.tn  = UNIT_FIRST;
						end
					end
					MODE_SERIAL: begin
						// R9 only the lowest data bit
						n.tsh = {link.txd[0], r.tsh[3:1]};
						n.tn  = r.tn + 2'h1;
						if (r.tn == UNITS_SERIAL_LAST) begin
							push  = 1'b1;
							pword = {!r.in_frame, link.txd[0], r.tsh[3:1]};
						end
					end
					default: begin
						push = 1'b0;
					end
				endcase
				if (push) begin
					n.in_frame = 1'b1;
				end
			end else begin
				// A partial nibble at frame end is dropped
				n.tn       = UNIT_FIRST;
				n.in_frame = 1'b0;
			end
		end
		// R16 receive outputs move at clock rise
		if (rtick && r.cfg_ok) begin
			n.crs = i_rx_crs || (rmii && r.rn != UNIT_FIRST);
			if (r.rn == UNIT_FIRST) begin
				n.rsh = i_rx_data;
				if (i_rx_valid) begin
					case (r.mode)
						MODE_MII: begin
							// R12 R15 valid and error
							n.rxd   = i_rx_data;
							n.rx_dv = 1'b1;
							n.rx_er = r.spd100 && i_rx_sym_err;
						end
						MODE_RMII: begin
							// R13 R18 valid and error
							n.rxd   = {2'b00, i_rx_data[1:0]};
							n.rn    = UNITS_RMII_LAST;
							n.rx_dv = 1'b1;
							n.rx_er = r.spd100 && i_rx_sym_err;
						end
						default: begin
							// R14 valid unused, carrier frames
							n.rxd   = {3'b000, i_rx_data[0]};
							n.rn    = 2'h1;
							n.rx_dv = 1'b0;
							n.rx_er = 1'b0;
						end
					endcase
				end else begin
					n.rxd   = '0;
					n.rx_dv = 1'b0;
					// R18 false carrier error
					n.rx_er = rmii && r.spd100 && i_false_carrier;
				end
			end else if (rmii) begin
				n.rxd = {2'b00, r.rsh[3:2]};
				n.rn  = UNIT_FIRST;
			end else begin
				n.rxd = {3'b000, r.rsh[r.rn]};
				n.rn  = r.rn + 2'h1;
			end
		end
		// R19 half duplex collision only
		n.col = !rmii && !r.fdx && r.cfg_ok && link.tx_en && i_rx_crs;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	phy_fifo #(
		.W (FIFO_WIDTH),
		.D (FIFO_DEPTH)
	) u_tx_fifo (
		.i_core_clk  (i_core_clk),
		.i_rst_b     (i_rst_b),
		.i_in_valid  (push),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (pword),
		.o_out_valid (o_tx_valid),
		.i_out_ready (i_tx_ready),
		.o_out_data  (fifo_out)
	);
endmodule : phy_port

module phy_dual (
	// Clock and reset
	input  wire logic                     i_core_clk,
	input  wire logic                     i_rst_b,
	// Per-port configuration, index 0 is port A
	input  wire phy_mac_pkg::mode_t [1:0] i_mode,
	input  wire logic [1:0]               i_speed_100,
	input  wire logic [1:0]               i_full_duplex,
	// MAC links
	phy_mac_if.phy                        link_a,
	phy_mac_if.phy                        link_b,
	// Line-side receive
	input  wire logic [1:0]               i_rx_crs,
	input  wire logic [1:0]               i_rx_valid,
	output logic [1:0]                    o_rx_ready,
	input  wire logic [1:0][3:0]          i_rx_data,
	input  wire logic [1:0]               i_rx_sym_err,
	input  wire logic [1:0]               i_false_carrier,
	// Line-side transmit
	output logic [1:0]                    o_tx_valid,
	input  wire logic [1:0]               i_tx_ready,
	output logic [1:0][3:0]               o_tx_data,
	output logic [1:0]                    o_tx_first
);
	import phy_mac_pkg::*;

	// R20 two independent ports
	phy_port u_port_a (
		.i_core_clk (i_core_clk), .i_rst_b (i_rst_b),
		.i_mode (i_mode[0]), .i_speed_100 (i_speed_100[0]),
		.i_full_duplex (i_full_duplex[0]), .link (link_a),
		.i_rx_crs (i_rx_crs[0]), .i_rx_valid (i_rx_valid[0]),
		.o_rx_ready (o_rx_ready[0]), .i_rx_data (i_rx_data[0]),
		.i_rx_sym_err (i_rx_sym_err[0]),
		.i_false_carrier (i_false_carrier[0]),
		.o_tx_valid (o_tx_valid[0]), .i_tx_ready (i_tx_ready[0]),
		.o_tx_data (o_tx_data[0]), .o_tx_first (o_tx_first[0])
	);
	phy_port u_port_b (
		.i_core_clk (i_core_clk), .i_rst_b (i_rst_b),
		.i_mode (i_mode[1]), .i_speed_100 (i_speed_100[1]),
		.i_full_duplex (i_full_duplex[1]), .link (link_b),
		.i_rx_crs (i_rx_crs[1]), .i_rx_valid (i_rx_valid[1]),
		.o_rx_ready (o_rx_ready[1]), .i_rx_data (i_rx_data[1]),
		.i_rx_sym_err (i_rx_sym_err[1]),
		.i_false_carrier (i_false_carrier[1]),
		.o_tx_valid (o_tx_valid[1]), .i_tx_ready (i_tx_ready[1]),
		.o_tx_data (o_tx_data[1]), .o_tx_first (o_tx_first[1])
	);
endmodule : phy_dual

// file: include/phy_mac_pkg.sv
// Shared constants and types for the MAC data interface of one PHY port
package phy_mac_pkg;
	typedef enum logic [1:0] {
		MODE_MII    = 2'b00,
		MODE_RMII   = 2'b01,
		MODE_SERIAL = 2'b10
	} mode_t;

	localparam int CORE_KHZ    = 100000;
	localparam int MII100_KHZ  = 25000;
	localparam int MII10_KHZ   = 2500;
	localparam int RMII_KHZ    = 50000;
	localparam int SERIAL_KHZ  = 10000;

	localparam logic [5:0] DIV_MII100 = 6'(CORE_KHZ / MII100_KHZ);
	localparam logic [5:0] DIV_MII10  = 6'(CORE_KHZ / MII10_KHZ);
	localparam logic [5:0] DIV_RMII   = 6'(CORE_KHZ / RMII_KHZ);
	localparam logic [5:0] DIV_SERIAL = 6'(CORE_KHZ / SERIAL_KHZ);

	localparam int NIB_W      = 4;
	localparam int FIFO_WIDTH = 5;
	localparam int FIFO_DEPTH = 16;

	localparam logic [1:0] UNITS_RMII_LAST   = 2'h1;
	localparam logic [1:0] UNITS_SERIAL_LAST = 2'h3;
	localparam logic [1:0] UNIT_FIRST        = 2'h0;
endpackage : phy_mac_pkg

// file: include/phy_mac_if.sv
// Link wires between one PHY port and its MAC
`timescale 1ns/1ps
interface phy_mac_if;
	logic       tx_clk;
	logic       rx_clk;
	logic       ref_clk;
	logic       tx_en;
	logic [3:0] txd;
	logic [3:0] rxd;
	logic       rx_dv;
	logic       rx_er;
	logic       crs;
	logic       col;

	modport phy (
		output tx_clk, rx_clk, ref_clk, rxd, rx_dv, rx_er, crs, col,
		input  tx_en, txd
	);
	modport mac (
		input  tx_clk, rx_clk, ref_clk, rxd, rx_dv, rx_er, crs, col,
		output tx_en, txd
	);
endinterface : phy_mac_if

// file: rtl/mac_end.sv
// MAC end of one link: drives transmit, collects receive nibbles
`timescale 1ns/1ps
module mac_end (
	// Clock and reset
	input  wire logic               i_core_clk,
	input  wire logic               i_rst_b,
	// Configuration, captured once after reset
	input  wire phy_mac_pkg::mode_t i_mode,
	// PHY link
	phy_mac_if.mac                  link,
	// Nibbles to send
	input  wire logic               i_tx_valid,
	output logic                    o_tx_ready,
	input  wire logic [3:0]         i_tx_data,
	// Received nibbles
	output logic                    o_rx_valid,
	output logic [3:0]              o_rx_data,
	output logic                    o_rx_err,
	output logic                    o_crs,
	output logic                    o_col
);
	import phy_mac_pkg::*;

	typedef struct packed {
		logic       cfg_ok;
		mode_t      mode;
		logic       tprev;
		logic       rprev;
		logic [3:0] tsh;
		logic [1:0] tn;
		logic       tx_en;
		logic [3:0] txd;
		logic [3:0] rsh;
		logic [1:0] rn;
		logic       rerr;
		logic       rx_valid;
		logic [3:0] rx_data;
		logic       rx_err;
		logic       crs;
		logic       col;
	} mac_st_t;
	mac_st_t r;
	mac_st_t n;
	logic    rmii;
	logic    ser;
	logic    tsrc;
	logic    rsrc;
	logic    trise;
	logic    rrise;
	logic    qual;

	assign rmii  = (r.mode == MODE_RMII);
	assign ser   = (r.mode == MODE_SERIAL);
	// R2 R8 RMII times both paths by reference
	assign tsrc  = rmii ? link.ref_clk : link.tx_clk;
	assign rsrc  = rmii ? link.ref_clk : link.rx_clk;
	assign trise = tsrc && !r.tprev;
	assign rrise = rsrc && !r.rprev;
	// R14 serial data framed by carrier
	assign qual  = ser ? link.crs : link.rx_dv;

	assign o_tx_ready = trise && r.cfg_ok && (r.tn == UNIT_FIRST);
	assign link.tx_en = r.tx_en;
	assign link.txd   = r.txd;
	assign o_rx_valid = r.rx_valid;
	assign o_rx_data  = r.rx_data;
	assign o_rx_err   = r.rx_err;
	assign o_crs      = r.crs;
	assign o_col      = r.col;

	always_comb begin
		n          = r;
		n.tprev    = tsrc;
		n.rprev    = rsrc;
		n.rx_valid = 1'b0;
		n.crs      = link.crs;
		n.col      = link.col;
		if (!r.cfg_ok) begin
			n.cfg_ok = 1'b1;
			n.mode   = i_mode;
		end
		// R3 R7 drive data after each rise
		if (trise && r.cfg_ok) begin
			if (r.tn == UNIT_FIRST) begin
				n.tsh = i_tx_data;
				// R4 R5 R6 enable spans valid data
				n.tx_en = i_tx_valid;
				if (!i_tx_valid) begin
					n.txd = '0;
				end else if (rmii) begin
					n.txd = {2'b00, i_tx_data[1:0]};
					n.tn  = UNITS_RMII_LAST;
				end else if (ser) begin
					// R9 one serial bit
					n.txd = {3'b000, i_tx_data[0]};
					n.tn  = 2'h1;
				end else begin
					n.txd = i_tx_data;
				end
			end else if (rmii) begin
				n.txd = {2'b00, r.tsh[3:2]};
				n.tn  = UNIT_FIRST;
			end else begin
				n.txd = {3'b000, r.tsh[r.tn]};
				n.tn  = r.tn + 2'h1;
			end
		end
		if (rrise && r.cfg_ok) begin
			if (!qual) begin
				n.rn   = UNIT_FIRST;
				n.rerr = 1'b0;
			end else if (rmii) begin
				if (r.rn == UNIT_FIRST) begin
					n.rsh[1:0] = link.rxd[1:0];
					n.rerr     = link.rx_er;
					n.rn       = UNITS_RMII_LAST;
				end else begin
					n.rx_valid = 1'b1;
					n.rx_data  = {link.rxd[1:0], r.rsh[1:0]};
					n.rx_err   = r.rerr || link.rx_er;
					n.rn       = UNIT_FIRST;
				end
			end else if (ser) begin
				n.rsh  = {link.rxd[0], r.rsh[3:1]};
				n.rn   = r.rn + 2'h1;
				if (r.rn == UNITS_SERIAL_LAST) begin
					n.rx_valid = 1'b1;
					n.rx_data  = {link.rxd[0], r.rsh[3:1]};
					n.rx_err   = 1'b0;
				end
			end else begin
				n.rx_valid = 1'b1;
				n.rx_data  = link.rxd;
				n.rx_err   = link.rx_er;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
endmodule : mac_end

// file: tb/phy_mac_link_checker.sv
// Concurrent checks on the wires of link A between PHY and MAC
`timescale 1ns/1ps
module phy_mac_link_checker (
	// Clock and reset
	input wire logic               i_core_clk,
	input wire logic               i_rst_b,
	// Port configuration
	input wire phy_mac_pkg::mode_t i_mode,
	input wire logic               i_full_duplex,
	// Link wires
	input wire logic               tx_clk,
	input wire logic               rx_clk,
	input wire logic               ref_clk,
	input wire logic               tx_en,
	input wire logic [3:0]         txd,
	input wire logic [3:0]         rxd,
	input wire logic               rx_dv,
	input wire logic               rx_er,
	input wire logic               col
);
	import phy_mac_pkg::*;
	logic [1:0] age_r;
	logic       live;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);

	// Config lands one edge after release, so skip the first edges
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			age_r <= 2'h0;
		else if (age_r != 2'h3)
			age_r <= age_r + 2'h1;
	end
	assign live = (age_r == 2'h3);

	rmii_clk_gate_a: assert property (live && i_mode == MODE_RMII
		|-> !tx_clk && !rx_clk) else $error("link clock in RMII");
	ref_clk_idle_a: assert property (live && i_mode != MODE_RMII
		|-> !ref_clk) else $error("reference clock outside RMII");
	ref_pulse_a: assert property (live && $rose(ref_clk) |=> !ref_clk)
		else $error("reference clock high too long");
	rx_clk_high_a: assert property (live && $rose(rx_clk) |=> rx_clk)
		else $error("receive clock high too short");
	serial_rx_period_a: assert property (live && i_mode == MODE_SERIAL
		&& $rose(rx_clk) |=> rx_clk[*4] ##1 !rx_clk[*5] ##1 rx_clk)
		else $error("serial receive clock period");
	serial_dv_low_a: assert property (live && i_mode == MODE_SERIAL
		|-> !rx_dv && !rx_er) else $error("valid or error in serial");
	rxd_idle_a: assert property (live && i_mode != MODE_SERIAL
		&& !rx_dv |-> rxd == 4'h0) else $error("data without valid");
	rx_er_frame_a: assert property (live && i_mode == MODE_MII
		&& rx_er |-> rx_dv) else $error("error outside frame");
	dv_on_clock_a: assert property (live && i_mode == MODE_MII
		&& $changed(rx_dv) |-> $rose(rx_clk)) else $error("valid off clock");
	col_duplex_a: assert property (live && (i_full_duplex
		|| i_mode == MODE_RMII) |-> !col) else $error("collision raised");
	tx_on_clock_a: assert property (live && tx_en && $past(tx_en)
		&& $changed(txd) |-> $past(tx_clk) || $past(ref_clk))
		else $error("transmit data off clock");
endmodule : phy_mac_link_checker

// file: tb/phy_mac_data_interface_tb_top.sv
// Bench joining the PHY and MAC ends of both ports
`timescale 1ns/1ps
module phy_mac_data_interface_tb_top;
	import phy_mac_pkg::*;
	logic            i_core_clk;
	logic            i_rst_b;
	mode_t [1:0]     mode;
	logic [1:0]      spd, fdx, crs, rv, se, fc, trdy, rrdy, tv, tf;
	logic [1:0]      mv, mrdy, mrv, mre, mcrs, mcol;
	logic [1:0][3:0] rd, td, md, mrd;
	logic [4:0]      txq[$];
	logic [4:0]      rxq[2][$];
	int              failures;
	int              comparisons;

	phy_mac_if lk[2] ();

	phy_dual phy_dual_inst (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
		.i_mode(mode), .i_speed_100(spd), .i_full_duplex(fdx),
		.link_a(lk[0].phy), .link_b(lk[1].phy), .i_rx_crs(crs),
		.i_rx_valid(rv), .o_rx_ready(rrdy), .i_rx_data(rd),
		.i_rx_sym_err(se), .i_false_carrier(fc), .o_tx_valid(tv),
		.i_tx_ready(trdy), .o_tx_data(td), .o_tx_first(tf));

	for (genvar g = 0; g < 2; g++) begin : g_mac
		mac_end mac_end_inst (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
			.i_mode(mode[g]), .link(lk[g].mac), .i_tx_valid(mv[g]),
			.o_tx_ready(mrdy[g]), .i_tx_data(md[g]), .o_rx_valid(mrv[g]),
			.o_rx_data(mrd[g]), .o_rx_err(mre[g]), .o_crs(mcrs[g]),
			.o_col(mcol[g]));
	end

	phy_mac_link_checker phy_mac_link_checker_inst (.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b), .i_mode(mode[0]), .i_full_duplex(fdx[0]),
		.tx_clk(lk[0].tx_clk), .rx_clk(lk[0].rx_clk),
		.ref_clk(lk[0].ref_clk), .tx_en(lk[0].tx_en), .txd(lk[0].txd),
		.rxd(lk[0].rxd), .rx_dv(lk[0].rx_dv), .rx_er(lk[0].rx_er),
		.col(lk[0].col));

	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end

	always @(posedge i_core_clk) begin
		if (tv[0] && trdy[0])
			txq.push_back({tf[0], td[0]});
		for (int p = 0; p < 2; p++)
			if (mrv[p])
				rxq[p].push_back({mre[p], mrd[p]});
	end

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	task automatic tally_and_finish;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish

	task automatic tick(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask : tick

	task automatic bail;
		check(8'h1, 8'h0);
		tally_and_finish();
	endtask : bail

	// Mode is only taken at the first edge after release
	task automatic setup(input mode_t ma, mb, input logic [1:0] s, f);
		i_rst_b = 1'b0;
		mode[0] = ma;
		mode[1] = mb;
		spd = s;
		fdx = f;
		txq.delete();
		rxq[0].delete();
		rxq[1].delete();
		tick(5);
		i_rst_b = 1'b1;
		tick(2);
	endtask : setup

	// Counts rises over 400 cycles: any window of whole periods is exact
	task automatic rises(input int sel, input int exp);
		logic [2:0] c, q;
		int n;
		n = 0;
		q = {lk[0].ref_clk, lk[0].rx_clk, lk[0].tx_clk};
		repeat (400) begin
			tick(1);
			c = {lk[0].ref_clk, lk[0].rx_clk, lk[0].tx_clk};
			n += int'(c[sel] & ~q[sel]);
			q = c;
		end
		check(8'(n), 8'(exp));
	endtask : rises

	task automatic mac_send(input int p, n, input logic [3:0] b);
		logic got;
		mv[p] = 1'b1;
		md[p] = b;
		for (int k = 0; n > 0; k++) begin
			@(posedge i_core_clk);
			got = mrdy[p];
			#1;
			if (got) begin
				n--;
				md[p] = md[p] + 4'h3;
			end
			if (k == 30000)
				bail();
		end
		mv[p] = 1'b0;
	endtask : mac_send

	task automatic line_send(input int p, n, input logic [3:0] b, input int e);
		logic got;
		crs[p] = 1'b1;
		rv[p] = 1'b1;
		rd[p] = b;
		se[p] = (e == 0);
		for (int k = 0, i = 0; i < n; k++) begin
			@(posedge i_core_clk);
			got = rrdy[p];
			#1;
			if (got) begin
				i++;
				rd[p] = rd[p] + 4'h5;
				se[p] = (i == e);
			end
			if (k == 30000)
				bail();
		end
		rv[p] = 1'b0;
		tick(60);
		crs[p] = 1'b0;
	endtask : line_send

	task automatic wait_len(input int q, input int n);
		for (int k = 0; (q < 0 ? txq.size() : rxq[q].size()) < n; k++) begin
			tick(1);
			if (k == 30000)
				bail();
		end
		tick(100);
	endtask : wait_len

	task automatic tx_expect(input int n, input logic [3:0] b);
		wait_len(-1, n);
		check(8'(txq.size()), 8'(n));
		for (int i = 0; i < n; i++)
			check(8'(txq[i]), {3'h0, i == 0, 4'(b + 3 * i)});
	endtask : tx_expect

	task automatic rx_expect(input int p, n, input logic [3:0] b,
		input int e, input logic er);
		wait_len(p, n);
		check(8'(rxq[p].size()), 8'(n));
		for (int i = 0; i < n; i++)
			check(8'(rxq[p][i]), {3'h0, er && i == e, 4'(b + 5 * i)});
	endtask : rx_expect

	task automatic t_mii;
		setup(MODE_MII, MODE_RMII, 2'b11, 2'b00);
		rises(0, 100);
		rises(1, 100);
		fork
			mac_send(0, 6, 4'h1);
			line_send(0, 5, 4'h2, 3);
			line_send(1, 4, 4'h9, 1);
		join
		tx_expect(6, 4'h1);
		rx_expect(0, 5, 4'h2, 3, 1'b1);
		rx_expect(1, 4, 4'h9, 1, 1'b1);
		setup(MODE_MII, MODE_SERIAL, 2'b00, 2'b11);
		rises(0, 10);
		rises(1, 10);
		fork
			mac_send(0, 3, 4'hA);
			line_send(0, 2, 4'h7, 0);
		join
		tx_expect(3, 4'hA);
		rx_expect(0, 2, 4'h7, 0, 1'b0);
		$display("test mii done");
	endtask : t_mii

	task automatic t_rmii;
		setup(MODE_RMII, MODE_MII, 2'b11, 2'b00);
		rises(0, 0);
		rises(2, 200);
		fork
			mac_send(0, 5, 4'h4);
			line_send(0, 4, 4'hC, 2);
		join
		tx_expect(5, 4'h4);
		rx_expect(0, 4, 4'hC, 2, 1'b1);
		// False carrier with no nibble still raises the error
		fc[0] = 1'b1;
		tick(6);
		check(8'(lk[0].rx_er), 8'h1);
		fc[0] = 1'b0;
		tick(6);
		check(8'(lk[0].rx_er), 8'h0);
		$display("test rmii done");
	endtask : t_rmii

	task automatic t_serial;
		setup(MODE_SERIAL, MODE_MII, 2'b00, 2'b00);
		rises(0, 40);
		rises(1, 40);
		fork
			mac_send(0, 4, 4'h6);
			line_send(0, 3, 4'hE, 1);
		join
		tx_expect(4, 4'h6);
		rx_expect(0, 3, 4'hE, 1, 1'b0);
		$display("test serial done");
	endtask : t_serial

	task automatic t_col;
		setup(MODE_MII, MODE_MII, 2'b11, 2'b10);
		crs = 2'b11;
		// Duplex changed after capture must not be seen
		fdx[1] = 1'b0;
		fork
			mac_send(0, 8, 4'h0);
			mac_send(1, 8, 4'h0);
		join_none
		tick(20);
		check(8'(mcol), 8'h1);
		check(8'(mcrs), 8'h3);
		wait fork;
		crs = 2'b00;
		$display("test collision done");
	endtask : t_col

	// Stalled drain fills the FIFO; the link clock must then stop
	task automatic t_fifo;
		setup(MODE_MII, MODE_RMII, 2'b11, 2'b00);
		trdy[0] = 1'b0;
		fork
			mac_send(0, 20, 4'h3);
		join_none
		tick(300);
		check(8'(txq.size()), 8'h0);
		check(8'(tv[0]), 8'h1);
		rises(0, 0);
		trdy[0] = 1'b1;
		wait fork;
		tx_expect(20, 4'h3);
		check(8'(tv[0]), 8'h0);
		$display("test fifo done");
	endtask : t_fifo

	initial begin
		failures = 0;
		comparisons = 0;
		i_rst_b = 1'b0;
		mode[0] = MODE_MII;
		mode[1] = MODE_MII;
		{spd, fdx, crs, rv, se, fc, mv} = '0;
		trdy = 2'b11;
		rd = '0;
		md = '0;
		t_mii();
		t_rmii();
		t_serial();
		t_col();
		t_fifo();
		tally_and_finish();
	end
endmodule : phy_mac_data_interface_tb_top
